// ### logic/sys_ctrl.sv
// clock select and divider, reset stretch, watchdog, power modes, iap sequencer
`timescale 1ns/100ps
module sys_ctrl #(
    parameter int unsigned PROG_CYCLES = sys_ctrl_pkg::IAP_PROG_CYC
) (
    input  wire logic       clk_i,          // oscillator clock
    input  wire logic       rst_b_i,        // power-on reset
    input  wire logic       sfr_wr_i,       // sfr write strobe
    input  wire logic [3:0] sfr_addr_i,     // sfr address
    input  wire logic [3:0] sfr_wdata_i,    // sfr write data
    output logic      [3:0] sfr_rdata_o,    // sfr read data, one cycle late
    input  wire logic       iff_wr_i,       // flag write strobe
    input  wire logic [3:0] iff_bit_i,      // flag number
    input  wire logic       iff_val_i,      // flag value
    input  wire logic [1:0] ptr_hi_i,       // pointer high nibble low bits
    input  wire logic [3:0] ptr_lo_i,       // pointer low nibble
    input  wire logic [3:0] gdata_hi_i,     // general data high
    input  wire logic [3:0] gdata_lo_i,     // general data low
    input  wire logic [7:0] port_pin_i,     // port one and port zero pins
    input  wire logic [2:0] cfg_word_i,     // flash config word
    input  wire logic [7:0] flash_rdata_i,  // flash read byte
    output logic            flash_req_o,    // flash access active
    output logic      [1:0] flash_op_o,     // flash operation
    output logic      [9:0] flash_addr_o,   // flash byte address
    output logic      [7:0] flash_wdata_o,  // flash write byte
    output logic      [7:0] iap_rdata_o,    // byte for general data pair
    output logic            iap_rvalid_o,   // read byte valid pulse
    output logic            iap_done_o,     // program done pulse
    output logic            cpu_stall_o,    // cpu halted by iap
    output logic            int_reset_o,    // internal reset
    output logic            sys_en_o,       // system clock enable
    output logic            ext_osc_en_o,   // external oscillator on
    output logic            ring_osc_en_o,  // ring oscillator on
    output logic            sleep_o,        // sleep mode
    output logic            stop_o          // stop mode
);
    logic [3:0]                           cfg_ff;
    logic [3:0]                           iap_ff;
    logic [5:0]                           div_cnt_ff;
    logic [5:0]                           div_mask;
    logic [7:0]                           pin_s1_ff;
    logic [7:0]                           pin_s2_ff;
    logic [sys_ctrl_pkg::WDT_WIDTH-1:0]   wdt_ff;
    logic [sys_ctrl_pkg::HOLD_WIDTH-1:0]  hold_ff;
    logic [15:0]                          op_cnt_ff;
    logic                                 int_rst_ff;
    logic                                 watchdog_restart_flag_ff;
    logic                                 watchdog_enable_flag_ff;
    logic                                 sleep_ff;
    logic                                 stop_ff;
    logic                                 map_hi_ff;
    logic                                 map_lo_ff;
    sys_ctrl_pkg::iap_state_t             st_ff;
    logic                                 sys_tick;
    logic                                 wr_ok;
    logic                                 iff_ok;
    logic                                 cfg_wr;
    logic                                 src_chg;
    logic                                 iap_wr;
    logic                                 map_ok;
    logic                                 permit;
    logic                                 iap_go;
    logic                                 prog_start;
    logic                                 sleep_set;
    logic                                 wdt_clr;
    logic                                 wdt_run;
    logic                                 wdt_ovf;
    logic                                 wake;
    logic                                 rst_req;
    logic [1:0]                           w_oper;
    logic [1:0]                           w_region;
    logic [15:0]                          prog_last;

    assign w_oper    = sfr_wdata_i[sys_ctrl_pkg::OPER_MSB:0];
    assign w_region  = sfr_wdata_i[sys_ctrl_pkg::REGION_MSB:sys_ctrl_pkg::REGION_LSB];
    assign prog_last = 16'(PROG_CYCLES - 1);

    // divide-by mask: code 7 is undefined and falls back to the slowest rate
    assign div_mask = 6'(sys_ctrl_pkg::DIV_MASK_FULL >> (sys_ctrl_pkg::DIV_ALL_ONES - cfg_ff[2:0]));
    // counter keeps running across divider changes, so no reset is needed
    assign sys_tick = ~stop_ff & (&(div_cnt_ff | ~div_mask));

    assign wr_ok   = sfr_wr_i & ~int_rst_ff & (st_ff == sys_ctrl_pkg::ST_IDLE);
    assign iff_ok  = iff_wr_i & ~int_rst_ff & (st_ff == sys_ctrl_pkg::ST_IDLE);
    assign cfg_wr  = wr_ok & (sfr_addr_i == sys_ctrl_pkg::ADDR_CLOCK_CONFIG);
    assign src_chg = cfg_wr
        & (sfr_wdata_i[sys_ctrl_pkg::CLK_SRC_BIT] != cfg_ff[sys_ctrl_pkg::CLK_SRC_BIT]);
    assign iap_wr  = wr_ok & (sfr_addr_i == sys_ctrl_pkg::ADDR_IAP_CONTROL);
    assign map_ok  = map_hi_ff & ~map_lo_ff;

    always_comb
    begin
        permit = 1'b0;
        if (w_oper == sys_ctrl_pkg::OPER_READ)
            permit = cfg_word_i[sys_ctrl_pkg::SELF_READ_PERMIT];
        else if (w_oper != sys_ctrl_pkg::OPER_NONE)
            permit = cfg_word_i[sys_ctrl_pkg::SELF_PROG_PERMIT];
    end

    // blocked writes store nothing and start nothing, but still force the watchdog enable flag on
    assign iap_go = iap_wr & map_ok & permit & (w_region != sys_ctrl_pkg::REGION_RESERVED)
        & ~((w_region == sys_ctrl_pkg::REGION_INFO) & (w_oper != sys_ctrl_pkg::OPER_READ));
    assign prog_start = iap_go & ((w_oper == sys_ctrl_pkg::OPER_ERASE)
        | (w_oper == sys_ctrl_pkg::OPER_WRITE));
    assign sleep_set = iff_ok & (iff_bit_i == sys_ctrl_pkg::FLAG_SLEEP) & iff_val_i;

    assign wdt_clr = watchdog_restart_flag_ff | int_rst_ff | sleep_set | prog_start;
    assign wdt_run = watchdog_enable_flag_ff & sys_tick;
    assign wdt_ovf = wdt_run & (&wdt_ff) & ~wdt_clr;
    // stop is only entered with every pin high, so any low pin is a change
    assign wake    = stop_ff & (pin_s2_ff != sys_ctrl_pkg::PINS_ALL_HIGH);
    assign rst_req = wdt_ovf | wake | src_chg;

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            pin_s1_ff <= sys_ctrl_pkg::PINS_ALL_HIGH;
            pin_s2_ff <= sys_ctrl_pkg::PINS_ALL_HIGH;
        end
        else
        begin
            pin_s1_ff <= port_pin_i;
            pin_s2_ff <= pin_s1_ff;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            div_cnt_ff <= '0;
        else if (!stop_ff)
            div_cnt_ff <= div_cnt_ff + 6'h01;
    end

    // only power-on clears the configuration; internal resets leave it
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            cfg_ff <= sys_ctrl_pkg::RST_CLOCK_CONFIG;
        else if (cfg_wr)
            cfg_ff <= sfr_wdata_i;
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            ext_osc_en_o  <= 1'b0;
            ring_osc_en_o <= 1'b1;
            sys_en_o      <= 1'b0;
            sfr_rdata_o   <= sys_ctrl_pkg::READ_UNMAPPED;
        end
        else
        begin
            ext_osc_en_o  <= cfg_ff[sys_ctrl_pkg::CLK_SRC_BIT] & ~stop_ff;
            ring_osc_en_o <= ~cfg_ff[sys_ctrl_pkg::CLK_SRC_BIT] & ~stop_ff;
            sys_en_o      <= sys_tick;
            if (sfr_addr_i == sys_ctrl_pkg::ADDR_IAP_CONTROL)
                sfr_rdata_o <= iap_ff;
            else if (sfr_addr_i == sys_ctrl_pkg::ADDR_CLOCK_CONFIG)
                sfr_rdata_o <= cfg_ff;
            else
                sfr_rdata_o <= sys_ctrl_pkg::READ_UNMAPPED;
        end
    end

    // hold time counts system clocks, so it stretches with the divider
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            int_rst_ff <= 1'b1;
            hold_ff    <= '0;
        end
        else if (rst_req)
        begin
            int_rst_ff <= 1'b1;
            hold_ff    <= '0;
        end
        else if (int_rst_ff && sys_tick)
        begin
            if (&hold_ff)
                int_rst_ff <= 1'b0;
            hold_ff <= hold_ff + 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            wdt_ff <= '0;
        else if (wdt_clr)
            wdt_ff <= '0;
        else if (wdt_run)
            wdt_ff <= wdt_ff + 1'b1;
    end

    // restart flag lives one cycle: the cycle it is seen, the count clears
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            watchdog_restart_flag_ff <= 1'b0;
        else
            watchdog_restart_flag_ff <= iff_ok & (iff_bit_i == sys_ctrl_pkg::FLAG_WDT_RESTART) & iff_val_i;
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            watchdog_enable_flag_ff   <= 1'b1;
            sleep_ff  <= 1'b0;
            stop_ff   <= 1'b0;
            map_hi_ff <= 1'b0;
            map_lo_ff <= 1'b0;
        end
        else if (int_rst_ff)
        begin
            watchdog_enable_flag_ff   <= 1'b1;
            sleep_ff  <= 1'b0;
            stop_ff   <= 1'b0;
            map_hi_ff <= 1'b0;
            map_lo_ff <= 1'b0;
        end
        else
        begin
            if (sleep_set || iap_wr)
                watchdog_enable_flag_ff <= 1'b1;
            else if (iff_ok && iff_bit_i == sys_ctrl_pkg::FLAG_WDT_ENABLE && map_ok)
                watchdog_enable_flag_ff <= iff_val_i;
            if (sleep_set)
                sleep_ff <= 1'b1;
            if (iff_ok && iff_bit_i == sys_ctrl_pkg::FLAG_STOP)
            begin
                if (!iff_val_i)
                    stop_ff <= 1'b0;
                else if (pin_s2_ff == sys_ctrl_pkg::PINS_ALL_HIGH)
                    stop_ff <= 1'b1;
            end
            if (iff_ok && iff_bit_i == sys_ctrl_pkg::FLAG_MAP_HIGH)
                map_hi_ff <= iff_val_i;
            if (iff_ok && iff_bit_i == sys_ctrl_pkg::FLAG_MAP_LOW)
                map_lo_ff <= iff_val_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            st_ff         <= sys_ctrl_pkg::ST_IDLE;
            iap_ff        <= sys_ctrl_pkg::RST_IAP_CONTROL;
            op_cnt_ff     <= '0;
            cpu_stall_o   <= 1'b0;
            flash_req_o   <= 1'b0;
            flash_op_o    <= sys_ctrl_pkg::OPER_NONE;
            flash_addr_o  <= '0;
            flash_wdata_o <= '0;
            iap_rdata_o   <= '0;
            iap_rvalid_o  <= 1'b0;
            iap_done_o    <= 1'b0;
        end
        else
        begin
            iap_rvalid_o <= 1'b0;
            iap_done_o   <= 1'b0;
            case (st_ff)
                sys_ctrl_pkg::ST_IDLE:
                begin
                    if (iap_go && w_oper != sys_ctrl_pkg::OPER_NONE)
                    begin
                        iap_ff        <= sfr_wdata_i;
                        op_cnt_ff     <= '0;
                        cpu_stall_o   <= 1'b1;
                        flash_req_o   <= 1'b1;
                        flash_op_o    <= w_oper;
                        flash_wdata_o <= {gdata_hi_i, gdata_lo_i};
                        if (w_region == sys_ctrl_pkg::REGION_INFO)
                            flash_addr_o <= sys_ctrl_pkg::BASE_INFO | {7'h00, ptr_lo_i[2:0]};
                        else if (w_region == sys_ctrl_pkg::REGION_DATA_HIGH)
                            flash_addr_o <= sys_ctrl_pkg::BASE_DATA_HIGH | {4'h0, ptr_hi_i, ptr_lo_i};
                        else
                            flash_addr_o <= sys_ctrl_pkg::BASE_DATA_LOW | {4'h0, ptr_hi_i, ptr_lo_i};
                        if (w_oper == sys_ctrl_pkg::OPER_READ)
                            st_ff <= sys_ctrl_pkg::ST_READ;
                        else
                            st_ff <= sys_ctrl_pkg::ST_PROG;
                    end
                end
                sys_ctrl_pkg::ST_READ:
                begin
                    if (sys_tick)
                    begin
                        op_cnt_ff <= op_cnt_ff + 16'h0001;
                        if (op_cnt_ff == sys_ctrl_pkg::IAP_READ_CYC - 16'h0001)
                        begin
                            iap_rdata_o  <= flash_rdata_i;
                            iap_rvalid_o <= 1'b1;
                            iap_ff       <= sys_ctrl_pkg::RST_IAP_CONTROL;
                            cpu_stall_o  <= 1'b0;
                            flash_req_o  <= 1'b0;
                            st_ff        <= sys_ctrl_pkg::ST_IDLE;
                        end
                    end
                end
                sys_ctrl_pkg::ST_PROG:
                begin
                    if (sys_tick)
                    begin
                        op_cnt_ff <= op_cnt_ff + 16'h0001;
                        if (op_cnt_ff == prog_last)
                        begin
                            iap_done_o  <= 1'b1;
                            iap_ff      <= sys_ctrl_pkg::RST_IAP_CONTROL;
                            cpu_stall_o <= 1'b0;
                            flash_req_o <= 1'b0;
                            st_ff       <= sys_ctrl_pkg::ST_IDLE;
                        end
                    end
                end
                default:
                    st_ff <= sys_ctrl_pkg::ST_IDLE;
            endcase
        end
    end

    assign sleep_o     = sleep_ff;
    assign stop_o      = stop_ff;
    assign int_reset_o = int_rst_ff;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    sequence s_read_begin;
        st_ff == sys_ctrl_pkg::ST_IDLE ##1 st_ff == sys_ctrl_pkg::ST_READ;
    endsequence
    sequence s_read_end;
        st_ff == sys_ctrl_pkg::ST_IDLE && iap_ff == sys_ctrl_pkg::RST_IAP_CONTROL && !cpu_stall_o;
    endsequence

    a_src_change_rst: assert property (src_chg |=> int_reset_o)
        else $error("source change did not raise reset");
    a_cfg_survives: assert property (int_rst_ff && !cfg_wr |=> $stable(cfg_ff))
        else $error("clock config altered by internal reset");
    a_osc_select: assert property (##1 !stop_ff && !$past(stop_ff)
        |-> ext_osc_en_o == $past(cfg_ff[sys_ctrl_pkg::CLK_SRC_BIT])
        && ring_osc_en_o != ext_osc_en_o)
        else $error("oscillator enables disagree with source bit");
    a_wdt_holds: assert property (!wdt_clr && (stop_ff || !watchdog_enable_flag_ff) |=> $stable(wdt_ff))
        else $error("watchdog moved while halted");
    a_wdt_overflow: assert property (wdt_run && (&wdt_ff) && !wdt_clr |=> int_reset_o
        && wdt_ff == '0)
        else $error("watchdog overflow missed");
    a_enable_gate: assert property (iff_ok && iff_bit_i == sys_ctrl_pkg::FLAG_WDT_ENABLE
        && !map_ok && !iap_wr |=> $stable(watchdog_enable_flag_ff))
        else $error("enable flag changed without map gate");
    a_enable_force: assert property (sleep_set || iap_wr || int_rst_ff |=> watchdog_enable_flag_ff)
        else $error("enable flag not forced");
    a_reset_hold: assert property (int_rst_ff && !(&hold_ff) && !rst_req |=> int_reset_o)
        else $error("internal reset released early");
    a_read_finish: assert property (s_read_begin |-> ##[1:400] s_read_end)
        else $error("iap read did not finish");
    a_info_protect: assert property (st_ff == sys_ctrl_pkg::ST_PROG
        |-> iap_ff[sys_ctrl_pkg::REGION_MSB:sys_ctrl_pkg::REGION_LSB]
        != sys_ctrl_pkg::REGION_INFO)
        else $error("programming the info region");
    a_stop_gate: assert property (!stop_ff && pin_s2_ff != sys_ctrl_pkg::PINS_ALL_HIGH
        |=> !stop_ff)
        else $error("stop entered with a pin low");
endmodule

// ### logic/sys_ctrl_pkg.sv
// constants and types shared by the system control block
package sys_ctrl_pkg;
    // special function register addresses, reset values and unmapped read value
    localparam logic [3:0] ADDR_IAP_CONTROL  = 4'h9;
    localparam logic [3:0] ADDR_CLOCK_CONFIG = 4'hD;
    localparam logic [3:0] RST_IAP_CONTROL   = 4'h0;
    localparam logic [3:0] RST_CLOCK_CONFIG  = 4'h0;
    localparam logic [3:0] READ_UNMAPPED     = 4'h0;
    // clock_config fields
    localparam int          CLK_SRC_BIT      = 3;
    localparam logic [2:0]  DIV_ALL_ONES     = 3'h7;
    localparam logic [6:0]  DIV_MASK_FULL    = 7'h7F;
    // iap_control fields and flash region base addresses
    localparam int          REGION_MSB       = 3;
    localparam int          REGION_LSB       = 2;
    localparam int          OPER_MSB         = 1;
    localparam logic [1:0]  REGION_DATA_LOW  = 2'h0;
    localparam logic [1:0]  REGION_DATA_HIGH = 2'h1;
    localparam logic [1:0]  REGION_INFO      = 2'h2;
    localparam logic [1:0]  REGION_RESERVED  = 2'h3;
    localparam logic [1:0]  OPER_NONE        = 2'h0;
    localparam logic [1:0]  OPER_READ        = 2'h1;
    localparam logic [1:0]  OPER_ERASE       = 2'h2;
    localparam logic [1:0]  OPER_WRITE       = 2'h3;
    localparam logic [9:0]  BASE_DATA_LOW    = 10'h1C0;
    localparam logic [9:0]  BASE_DATA_HIGH   = 10'h3C0;
    localparam logic [9:0]  BASE_INFO        = 10'h000;
    // indirect_flag_space bit numbers
    localparam logic [3:0]  FLAG_STOP        = 4'hF;
    localparam logic [3:0]  FLAG_SLEEP       = 4'hE;
    localparam logic [3:0]  FLAG_WDT_ENABLE  = 4'hD;
    localparam logic [3:0]  FLAG_WDT_RESTART = 4'hC;
    localparam logic [3:0]  FLAG_MAP_HIGH    = 4'hB;
    localparam logic [3:0]  FLAG_MAP_LOW     = 4'hA;
    // flash_config_word bits
    localparam int          SELF_READ_PERMIT = 1;
    localparam int          SELF_PROG_PERMIT = 2;
    // timing: counter widths in bits, read count in system clocks, program time in us and clock in kHz
    localparam int          WDT_WIDTH        = 17;
    localparam int          HOLD_WIDTH       = 12;
    localparam logic [15:0] IAP_READ_CYC     = 16'h0006;
    localparam int          IAP_PROG_TIME_US = 2000;
    localparam int          IAP_FSYS_KHZ     = 8000;
    localparam int          IAP_PROG_CYC     = (IAP_PROG_TIME_US * IAP_FSYS_KHZ + 999) / 1000;
    localparam logic [7:0]  PINS_ALL_HIGH    = 8'hFF;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_READ = 3'h2,
        ST_PROG = 3'h4
    } iap_state_t;
endpackage

// ### test/flash_model.sv
// flash array model that answers the iap sequencer
`timescale 1ns/100ps
module flash_model (
    input  wire logic       clk_i,   // system clock
    input  wire logic       req_i,   // access active
    input  wire logic [1:0] op_i,    // operation
    input  wire logic [9:0] addr_i,  // byte address
    input  wire logic [7:0] wdata_i, // byte to program
    output logic      [7:0] rdata_o  // byte read
);
    logic [7:0] mem [1024];
    initial
    begin
        for (int i = 0; i < 1024; i++)
            mem[i] = 8'h5A ^ i[7:0];
        rdata_o = 8'h00;
    end
    // lines are undriven outside a read, so they toggle instead of holding
    always @(posedge clk_i)
    begin
        if (req_i && op_i == sys_ctrl_pkg::OPER_READ)
            rdata_o <= mem[addr_i];
        else
            rdata_o <= ~rdata_o;
        if (req_i && op_i == sys_ctrl_pkg::OPER_ERASE)
            mem[addr_i] <= 8'hFF;
        if (req_i && op_i == sys_ctrl_pkg::OPER_WRITE)
            mem[addr_i] <= mem[addr_i] & wdata_i;
    end
endmodule

// ### test/sys_ctrl_bench.sv
// self-checking bench for the system control block
`timescale 1ns/100ps
module sys_ctrl_bench;
    localparam int unsigned PROG = 8;
    logic       clk_i, rst_b_i, sfr_wr_i, iff_wr_i, iff_val_i;
    logic [3:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o, iff_bit_i, ptr_lo_i, gd_h, gd_l;
    logic [1:0] ptr_hi_i, flash_op_o;
    logic [7:0] port_pin_i, flash_rdata_i, flash_wdata_o, iap_rdata_o;
    logic [2:0] cfg_word_i;
    logic [9:0] flash_addr_o;
    logic       flash_req_o, iap_rvalid_o, iap_done_o, cpu_stall_o, int_reset_o;
    logic       sys_en_o, ext_osc_en_o, ring_osc_en_o, stop_o, sleep_o;
    int         err_count, checks, n;

    sys_ctrl #(.PROG_CYCLES(PROG)) dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .sfr_wr_i(sfr_wr_i), .sfr_addr_i(sfr_addr_i), .sfr_wdata_i(sfr_wdata_i),
        .sfr_rdata_o(sfr_rdata_o), .iff_wr_i(iff_wr_i), .iff_bit_i(iff_bit_i),
        .iff_val_i(iff_val_i), .ptr_hi_i(ptr_hi_i), .ptr_lo_i(ptr_lo_i),
        .gdata_hi_i(gd_h), .gdata_lo_i(gd_l), .port_pin_i(port_pin_i),
        .cfg_word_i(cfg_word_i), .flash_rdata_i(flash_rdata_i), .flash_req_o(flash_req_o),
        .flash_op_o(flash_op_o), .flash_addr_o(flash_addr_o), .flash_wdata_o(flash_wdata_o),
        .iap_rdata_o(iap_rdata_o), .iap_rvalid_o(iap_rvalid_o), .iap_done_o(iap_done_o),
        .cpu_stall_o(cpu_stall_o), .int_reset_o(int_reset_o), .sys_en_o(sys_en_o),
        .ext_osc_en_o(ext_osc_en_o), .ring_osc_en_o(ring_osc_en_o), .sleep_o(sleep_o),
        .stop_o(stop_o));
    flash_model flash_u (.clk_i(clk_i), .req_i(flash_req_o), .op_i(flash_op_o),
        .addr_i(flash_addr_o), .wdata_i(flash_wdata_o), .rdata_o(flash_rdata_i));

    task automatic summarize();
        $display("checks=%0d err_count=%0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic sfr_wr(input logic [3:0] a, input logic [3:0] d);
        @(posedge clk_i);
        sfr_wr_i <= 1'b1;
        sfr_addr_i <= a;
        sfr_wdata_i <= d;
        @(posedge clk_i);
        sfr_wr_i <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, input logic [3:0] exp);
        @(posedge clk_i);
        sfr_addr_i <= a;
        @(posedge clk_i);
        #1 chk(sfr_rdata_o, exp);
    endtask
    task automatic flag(input logic [3:0] b, input logic v);
        @(posedge clk_i);
        iff_wr_i <= 1'b1;
        iff_bit_i <= b;
        iff_val_i <= v;
        @(posedge clk_i);
        iff_wr_i <= 1'b0;
        #1;
    endtask
    // waits out the reset stretch, n returns its length in clocks
    task automatic wait_rst();
        n = 0;
        while (int_reset_o !== 1'b0 && n < 5000)
        begin
            @(posedge clk_i);
            #1 n++;
        end
    endtask
    task automatic t_clock();
        rd(4'hD, sys_ctrl_pkg::RST_CLOCK_CONFIG);
        rd(4'hF, sys_ctrl_pkg::READ_UNMAPPED);
        chk({ring_osc_en_o, ext_osc_en_o}, 2'b10);
        for (int d = 0; d < 7; d++)
        begin
            sfr_wr(4'hD, d[3:0]);
            repeat (70) @(posedge clk_i);
            n = 0;
            repeat (128)
            begin
                @(posedge clk_i);
                #1 n += sys_en_o;
            end
            chk(n, 128 >> d);
        end
        sfr_wr(4'hD, 4'h8);
        chk(int_reset_o, 1'b1);
        wait_rst();
        chk(n >= 4094 && n <= 4100, 1'b1);
        chk({ring_osc_en_o, ext_osc_en_o}, 2'b01);
        rd(4'hD, 4'h8);
        sfr_wr(4'hD, 4'h0);
        wait_rst();
    endtask
    task automatic t_iap();
        logic [1:0] op;
        logic [2:0] cw [5] = '{3'h4, 3'h2, 3'h6, 3'h6, 3'h6};
        logic [3:0] cr [5] = '{4'h1, 4'h2, 4'hB, 4'hD, 4'h5};
        flag(sys_ctrl_pkg::FLAG_MAP_HIGH, 1'b1);
        cfg_word_i <= 3'h6;
        {gd_h, gd_l, ptr_hi_i, ptr_lo_i} <= {8'hC3, 6'h25};
        // the last pass reads back the byte that erase and write left behind
        for (int k = 0; k < 5; k++)
        begin
            op = (k == 4) ? 2'h1 : k[1:0];
            sfr_wr(4'h9, {2'h1, op});
            chk(cpu_stall_o, op != 2'h0);
            if (op != 2'h0)
                chk({flash_req_o, flash_op_o, flash_addr_o}, {1'b1, op, 10'h3E5});
            if (op == 2'h3)
                chk(flash_wdata_o, 8'hC3);
            n = 0;
            while (op != 2'h0 && !(iap_rvalid_o === 1'b1 || iap_done_o === 1'b1) && n < 40)
            begin
                @(posedge clk_i);
                #1 n++;
            end
            chk(n, op == 2'h0 ? 0 : (op == 2'h1 ? 6 : PROG));
            if (op == 2'h1)
                chk(iap_rdata_o, (k == 4) ? 8'hC3 : 8'h5A ^ 8'hE5);
            rd(4'h9, 4'h0);
        end
        for (int k = 0; k < 5; k++)
        begin
            if (k == 4)
                flag(sys_ctrl_pkg::FLAG_MAP_LOW, 1'b1);
            cfg_word_i <= cw[k];
            sfr_wr(4'h9, cr[k]);
            chk(cpu_stall_o, 1'b0);
        end
    endtask
    task automatic t_stop();
        flag(sys_ctrl_pkg::FLAG_SLEEP, 1'b1);
        chk(sleep_o, 1'b1);
        port_pin_i <= 8'hFE;
        repeat (4) @(posedge clk_i);
        flag(sys_ctrl_pkg::FLAG_STOP, 1'b1);
        chk(stop_o, 1'b0);
        port_pin_i <= 8'hFF;
        repeat (4) @(posedge clk_i);
        flag(sys_ctrl_pkg::FLAG_STOP, 1'b1);
        chk(stop_o, 1'b1);
        repeat (3) @(posedge clk_i);
        #1 chk({ring_osc_en_o, ext_osc_en_o}, 2'b00);
        port_pin_i <= 8'hEF;
        n = 0;
        while (int_reset_o !== 1'b1 && n < 10)
        begin
            @(posedge clk_i);
            #1 n++;
        end
        chk(n <= 4, 1'b1);
        port_pin_i <= 8'hFF;
        wait_rst();
        chk({sleep_o, stop_o}, 2'b00);
    endtask

    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    initial
    begin
        #400000;
        err_count++;
        summarize();
    end
    initial
    begin
        {rst_b_i, sfr_wr_i, iff_wr_i, iff_val_i, sfr_addr_i, sfr_wdata_i} = '0;
        {iff_bit_i, ptr_hi_i, ptr_lo_i, gd_h, gd_l, cfg_word_i} = '0;
        port_pin_i = 8'hFF;
        repeat (5) @(posedge clk_i);
        rst_b_i <= 1'b1;
        wait_rst();
        // t_clock leaves the divider at code 0, inside the programming clock range
        t_clock();
        t_iap();
        t_stop();
        summarize();
    end
endmodule
